// ---- mcg_params.svh ----
// Constants for the module clock gate control block: offsets, fields,
// reset values and timing counts. Included by the package and the top.
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH

// Register byte offsets on the bus
`define MCG_ADR_W          8
`define MCG_OFF_CTRL       8'h00
`define MCG_OFF_STAT       8'h04
`define MCG_OFF_OSC        8'h08

// Fields of module_clock_ctrl
`define MCG_CTRL_DIS_REQ   0
`define MCG_CTRL_DIS_STAT  1
`define MCG_CTRL_SLP_IGN   3

// Fields of the status register
`define MCG_STAT_SLEEP     0
`define MCG_STAT_CLK_EN    1
`define MCG_STAT_OSC_EXT   2

// Fields of the oscillator control register
`define MCG_OSC_EXT_MODE   0

// Reset values
`define MCG_RST_DIS_REQ    1'h0
`define MCG_RST_SLP_IGN    1'h0
`define MCG_RST_OSC_EXT    1'h1

// Time for the kernel clock gate to settle, and its cycle count (rounded up)
`define MCG_CLK_PERIOD_NS  5
`define MCG_GATE_SETTLE_NS 10
`define MCG_GATE_SETTLE_CYC ((`MCG_GATE_SETTLE_NS + `MCG_CLK_PERIOD_NS - 1) / `MCG_CLK_PERIOD_NS)

`endif

// ---- mcg_pkg.sv ----
// Types for the module clock gate control block.
// Assumes mcg_params.svh is on the include path.
`include "mcg_params.svh"

package mcg_pkg;

  // Which flavour of module the control sits in
  typedef enum logic [1:0] {
    MCG_VAR_FULL,
    MCG_VAR_NO_SLP_IGN,
    MCG_VAR_CHECKSUM
  } mcg_variant_t;

  // Kernel clock gate sequencing
  typedef enum logic [1:0] {
    MCG_RUN,
    MCG_STOP,
    MCG_OFF,
    MCG_START
  } mcg_state_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [3:0]             sel;
    logic [`MCG_ADR_W-1:0]  adr;
    logic [31:0]            dat;
  } mcg_wb_req_t;

endpackage

// ---- mcg_top.sv ----
// Module clock gate control: disable request/status, sleep handling,
// oscillator input-mode control, reached over a classic Wishbone slave.
// Assumes clk is the peripheral bus clock and sleep_req comes from logic on clk.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`include "mcg_params.svh"

// Behaviour
// - Software disable request bit at position 0
// - Read-only disable status bit at position 1
// - Sleep-ignore zero lets sleep request through
// - Sleep-ignore one blocks the sleep request
// - Some variants have no sleep-ignore control
// - Checksum variant: bit stored, without effect
// - Kernel clock is the peripheral bus clock
// - Oscillator external input mode after power-on reset
module mcg_top
  import mcg_pkg::*;
#(
  parameter mcg_variant_t VARIANT = MCG_VAR_FULL
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire mcg_wb_req_t wb_req,
  output logic             wb_ack,
  output logic [31:0]      wb_dat_o,
  // Sleep controller
  input  wire logic        sleep_req,
  output logic             module_sleep,
  // Kernel clock and oscillator
  output logic             kernel_clk_en,
  output logic             osc_ext_mode
);

  localparam logic [1:0] SETTLE_LAST = 2'(`MCG_GATE_SETTLE_CYC - 1);

  logic       ack_q;
  logic [31:0] rdat_q;
  logic       dis_req_q;
  logic       slp_ign_q;
  logic       dis_stat_q;
  logic       sleep_q;
  logic       clk_en_q;
  logic       osc_ext_q;
  logic [1:0] cnt_q;
  mcg_state_t state_q;
  logic       acc;
  logic       wr_ctrl;
  logic       wr_osc;
  logic       ign_eff;
  logic       stop_want;

  // Bus access decode: one access per request, answered the next cycle
  assign acc     = wb_req.cyc & wb_req.stb & ~ack_q;
  assign wr_ctrl = acc & wb_req.we & wb_req.sel[0] & (wb_req.adr == `MCG_OFF_CTRL);
  assign wr_osc  = acc & wb_req.we & wb_req.sel[0] & (wb_req.adr == `MCG_OFF_OSC);

  // Sleep-ignore acts only in the full variant
  assign ign_eff   = (VARIANT == MCG_VAR_FULL) & slp_ign_q;
  assign stop_want = dis_req_q | sleep_q;

  // Acknowledge: one cycle high, then low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // Read data; unmapped offsets read as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdat_q <= 32'h0;
    end else if (acc && !wb_req.we) begin
      rdat_q <= 32'h0;
      case (wb_req.adr)
        `MCG_OFF_CTRL: begin
          rdat_q[`MCG_CTRL_DIS_REQ]  <= dis_req_q;
          rdat_q[`MCG_CTRL_DIS_STAT] <= dis_stat_q;
          rdat_q[`MCG_CTRL_SLP_IGN]  <= slp_ign_q;
        end
        `MCG_OFF_STAT: begin
          rdat_q[`MCG_STAT_SLEEP]   <= sleep_q;
          rdat_q[`MCG_STAT_CLK_EN]  <= clk_en_q;
          rdat_q[`MCG_STAT_OSC_EXT] <= osc_ext_q;
        end
        `MCG_OFF_OSC: begin
          rdat_q[`MCG_OSC_EXT_MODE] <= osc_ext_q;
        end
        default: begin
          rdat_q <= 32'h0;
        end
      endcase
    end
  end

  // Control bits written by software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dis_req_q <= `MCG_RST_DIS_REQ;
      slp_ign_q <= `MCG_RST_SLP_IGN;
    end else if (wr_ctrl) begin
      dis_req_q <= wb_req.dat[`MCG_CTRL_DIS_REQ];
      if (VARIANT != MCG_VAR_NO_SLP_IGN) begin
        slp_ign_q <= wb_req.dat[`MCG_CTRL_SLP_IGN];
      end
    end
  end

  // Oscillator starts in external input mode until software changes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_ext_q <= `MCG_RST_OSC_EXT;
    end else if (wr_osc) begin
      osc_ext_q <= wb_req.dat[`MCG_OSC_EXT_MODE];
    end
  end

  // Sleep request honoured or disregarded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_req & ~ign_eff;
    end
  end

  // Kernel clock gate sequencing; status follows the real gate state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= MCG_RUN;
      clk_en_q   <= 1'b1;
      dis_stat_q <= 1'b0;
      cnt_q      <= 2'h0;
    end else begin
      case (state_q)
        MCG_RUN: begin
          if (stop_want) begin
            clk_en_q <= 1'b0;
            cnt_q    <= 2'h0;
            state_q  <= MCG_STOP;
          end
        end
        MCG_STOP: begin
          if (cnt_q == SETTLE_LAST) begin
            dis_stat_q <= 1'b1;
            state_q    <= MCG_OFF;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        MCG_OFF: begin
          if (!stop_want) begin
            clk_en_q <= 1'b1;
            cnt_q    <= 2'h0;
            state_q  <= MCG_START;
          end
        end
        MCG_START: begin
          if (cnt_q == SETTLE_LAST) begin
            dis_stat_q <= 1'b0;
            state_q    <= MCG_RUN;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        default: begin
          state_q <= MCG_RUN;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack        = ack_q;
  assign wb_dat_o      = rdat_q;
  assign module_sleep  = sleep_q;
  assign kernel_clk_en = clk_en_q;
  assign osc_ext_mode  = osc_ext_q;

  // Checks
  property p_dis_req_store;
    @(posedge clk) disable iff (!rstn)
      wr_ctrl |=> dis_req_q == $past(wb_req.dat[`MCG_CTRL_DIS_REQ]);
  endproperty
  a_dis_req_store: assert property (p_dis_req_store) else $error("disable request not stored");

  property p_stat_gate;
    @(posedge clk) disable iff (!rstn)
      (dis_stat_q && clk_en_q) |-> state_q == MCG_START;
  endproperty
  a_stat_gate: assert property (p_stat_gate) else $error("status disabled while clock runs");

  property p_sleep_honour;
    @(posedge clk) disable iff (!rstn)
      (sleep_req && !ign_eff) |=> module_sleep;
  endproperty
  a_sleep_honour: assert property (p_sleep_honour) else $error("sleep request not honoured");

  property p_sleep_ignore;
    @(posedge clk) disable iff (!rstn)
      ign_eff |=> !module_sleep;
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("ignored sleep entered");

  property p_no_ign_variant;
    @(posedge clk) disable iff (!rstn)
      (VARIANT == MCG_VAR_NO_SLP_IGN) |-> !slp_ign_q;
  endproperty
  a_no_ign_variant: assert property (p_no_ign_variant) else $error("absent sleep-ignore bit set");

  property p_checksum_store;
    @(posedge clk) disable iff (!rstn)
      (VARIANT == MCG_VAR_CHECKSUM && wr_ctrl) |=> slp_ign_q == $past(wb_req.dat[`MCG_CTRL_SLP_IGN]) && !ign_eff;
  endproperty
  a_checksum_store: assert property (p_checksum_store) else $error("checksum variant bit wrong");

  property p_gate_cause;
    @(posedge clk) disable iff (!rstn)
      $fell(clk_en_q) |-> $past(stop_want);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("kernel clock stopped without cause");

  property p_osc_change;
    @(posedge clk) disable iff (!rstn)
      $fell(osc_ext_q) |-> $past(wr_osc);
  endproperty
  a_osc_change: assert property (p_osc_change) else $error("oscillator mode left without write");

  property p_status_lag;
    @(posedge clk) disable iff (!rstn)
      $rose(dis_stat_q) |-> $past(clk_en_q, 3) && !$past(clk_en_q, 2) && !clk_en_q;
  endproperty
  a_status_lag: assert property (p_status_lag) else $error("disable status not lagging gate");

  property p_ack_pulse;
    @(posedge clk) disable iff (!rstn)
      wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  // Every taken access is answered on the next edge
  property p_ack_answer;
    @(posedge clk) disable iff (!rstn)
      acc |=> wb_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("access not answered in one cycle");

  // Read of the control register returns the request bit
  property p_rdat_ctrl;
    @(posedge clk) disable iff (!rstn)
      (acc && !wb_req.we && wb_req.adr == `MCG_OFF_CTRL) |=> wb_dat_o[`MCG_CTRL_DIS_REQ] == $past(dis_req_q);
  endproperty
  a_rdat_ctrl: assert property (p_rdat_ctrl) else $error("disable request read back wrong");

  // Parked with the gate closed means status reads disabled
  property p_gate_off;
    @(posedge clk) disable iff (!rstn)
      (state_q == MCG_OFF) |-> dis_stat_q && !clk_en_q;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("stopped module not reported disabled");

  // Full variant stores the sleep-ignore bit as written
  property p_slp_ign_store;
    @(posedge clk) disable iff (!rstn)
      (VARIANT == MCG_VAR_FULL && wr_ctrl) |=> slp_ign_q == $past(wb_req.dat[`MCG_CTRL_SLP_IGN]);
  endproperty
  a_slp_ign_store: assert property (p_slp_ign_store) else $error("sleep-ignore bit not stored");

  // Status register shows the real kernel clock gate
  property p_stat_rdat;
    @(posedge clk) disable iff (!rstn)
      (acc && !wb_req.we && wb_req.adr == `MCG_OFF_STAT) |=> wb_dat_o[`MCG_STAT_CLK_EN] == $past(clk_en_q);
  endproperty
  a_stat_rdat: assert property (p_stat_rdat) else $error("kernel clock state read back wrong");

  // Oscillator mode follows software once written
  property p_osc_write;
    @(posedge clk) disable iff (!rstn)
      wr_osc |=> osc_ext_q == $past(wb_req.dat[`MCG_OSC_EXT_MODE]);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("oscillator mode write lost");

  // Status clears only two edges after the clock is back
  property p_restart_lag;
    @(posedge clk) disable iff (!rstn)
      $fell(dis_stat_q) |-> !$past(clk_en_q, 3) && $past(clk_en_q, 2) && clk_en_q;
  endproperty
  a_restart_lag: assert property (p_restart_lag) else $error("enable status not lagging gate");

  // Running state keeps the clock on and status enabled
  property p_run_state;
    @(posedge clk) disable iff (!rstn)
      (state_q == MCG_RUN) |-> clk_en_q && !dis_stat_q;
  endproperty
  a_run_state: assert property (p_run_state) else $error("running module not reported enabled");

endmodule // mcg_top

// ---- mcg_slp_model.sv ----
// Sleep controller model driving the block's sleep request.
// Assumes it runs on the peripheral bus clock, like the block.
`timescale 1ns/100ps
module mcg_slp_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Command from the bench, request to the block
  input  wire logic want,
  output logic      sleep_req
);
  // Request is a level launched just after the rising edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_req <= 1'h0;
    end else begin
      sleep_req <= want;
    end
  end
endmodule // mcg_slp_model

// ---- tb_module_clock_gate_control.sv ----
// Self-checking bench for the module clock gate control block.
// Assumes one 200 MHz clock; checks the full variant, with the checksum and no-ignore variants alongside.
`timescale 1ns/100ps
module tb_module_clock_gate_control;
  import mcg_pkg::*;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        want = 1'h0;
  mcg_wb_req_t req = '0;
  logic        wb_ack, module_sleep, kernel_clk_en, osc_ext_mode, sleep_req;
  logic [31:0] wb_dat_o, q;
  logic        module_sleep_c, module_sleep_n;
  logic [31:0] dat_c, dat_n, q_c, q_n;
  int          err_count = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  mcg_slp_model i_mcg_slp_model (.clk(clk), .rstn(rstn), .want(want), .sleep_req(sleep_req));
  mcg_top #(.VARIANT(MCG_VAR_FULL)) i_mcg_top (.clk(clk), .rstn(rstn), .wb_req(req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .sleep_req(sleep_req), .module_sleep(module_sleep),
    .kernel_clk_en(kernel_clk_en), .osc_ext_mode(osc_ext_mode));
  // Checksum and no-ignore variants share the bus and the sleep request
  mcg_top #(.VARIANT(MCG_VAR_CHECKSUM)) i_mcg_top_cks (.clk(clk), .rstn(rstn), .wb_req(req), .wb_ack(),
    .wb_dat_o(dat_c), .sleep_req(sleep_req), .module_sleep(module_sleep_c), .kernel_clk_en(), .osc_ext_mode());
  mcg_top #(.VARIANT(MCG_VAR_NO_SLP_IGN)) i_mcg_top_nsi (.clk(clk), .rstn(rstn), .wb_req(req), .wb_ack(),
    .wb_dat_o(dat_n), .sleep_req(sleep_req), .module_sleep(module_sleep_n), .kernel_clk_en(), .osc_ext_mode());

  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    req <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'h1);
    q = wb_dat_o;
    q_c = dat_c;
    q_n = dat_n;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    chk("osc_mode", 32'(osc_ext_mode), 32'h1);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h0);
    wb(1'h0, 8'h04, 32'h0);
    chk("stat", q, 32'h6);
    $display("test reset done");
  endtask

  task automatic t_disable;
    wb(1'h1, 8'h00, 32'h3);
    chk("clk_en", 32'(kernel_clk_en), 32'h0);
    repeat (4) @(posedge clk);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_dis", q, 32'h3);
    wb(1'h1, 8'h00, 32'h0);
    chk("clk_en_on", 32'(kernel_clk_en), 32'h1);
    repeat (4) @(posedge clk);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_en", q, 32'h0);
    $display("test disable done");
  endtask

  task automatic t_sleep;
    wb(1'h1, 8'h00, 32'h8);
    want <= 1'h1;
    repeat (6) @(posedge clk);
    chk("sleep_ign", 32'(module_sleep), 32'h0);
    chk("clk_kept", 32'(kernel_clk_en), 32'h1);
    wb(1'h1, 8'h00, 32'h0);
    repeat (6) @(posedge clk);
    chk("sleep_ok", 32'(module_sleep), 32'h1);
    wb(1'h0, 8'h04, 32'h0);
    chk("stat_slp", q, 32'h5);
    want <= 1'h0;
    repeat (6) @(posedge clk);
    chk("clk_back", 32'(kernel_clk_en), 32'h1);
    $display("test sleep done");
  endtask

  // Sleep-ignore written to all three variants (not stored by no-ignore), then a sleep request
  task automatic t_variant;
    wb(1'h1, 8'h00, 32'h8);
    want <= 1'h1;
    repeat (8) @(posedge clk);
    chk("full_ign", 32'(module_sleep), 32'h0);
    chk("cks_sleep", 32'(module_sleep_c), 32'h1);
    chk("nsi_sleep", 32'(module_sleep_n), 32'h1);
    wb(1'h0, 8'h00, 32'h0);
    chk("full_ctrl", q, 32'h8);
    chk("cks_ctrl", q_c, 32'hA);
    chk("nsi_ctrl", q_n, 32'h2);
    want <= 1'h0;
    wb(1'h1, 8'h00, 32'h0);
    repeat (8) @(posedge clk);
    $display("test variant done");
  endtask

  // Reset in mid-run brings the oscillator back to external input mode
  task automatic t_rereset;
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    chk("osc_rst", 32'(osc_ext_mode), 32'h1);
    wb(1'h0, 8'h08, 32'h0);
    chk("osc_rst_rd", q, 32'h1);
    $display("test rereset done");
  endtask

  task automatic t_map;
    wb(1'h1, 8'h0C, 32'hFFFFFFFF);
    wb(1'h0, 8'h0C, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'h1, 8'h08, 32'h0);
    chk("osc_off", 32'(osc_ext_mode), 32'h0);
    wb(1'h0, 8'h08, 32'h0);
    chk("osc_rd", q, 32'h0);
    $display("test map done");
  endtask

  // Verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_reset();
    t_disable();
    t_sleep();
    t_variant();
    t_map();
    t_rereset();
    end_of_test();
  end

  // Watchdog, well beyond the hundred or so cycles of the tests
  initial begin
    #25000;
    err_count++;
    end_of_test();
  end
endmodule // tb_module_clock_gate_control
